// [src/fcs_pkg.sv]
// package: constants and types of the flash command sequencer host
package fcs_pkg;

	localparam int CLK_MHZ = 40;
	localparam int WE_PULSE_NS = 40;
	localparam int WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYCLE_TIME_NS = 70;
	localparam int READ_CYCLE_CYC = (READ_CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_RECOVERY_TIME_NS = 1000;
	localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SUSPEND_LATENCY_US = 20;
	localparam int SUSPEND_WAIT_CYC = SUSPEND_LATENCY_US * CLK_MHZ;
	localparam int POLL_TIMEOUT_MS = 100;
	localparam int POLL_TIMEOUT_CYC_DEF = POLL_TIMEOUT_MS * CLK_MHZ * 1000;

	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] ADDR_OFS = 8'h04;
	localparam logic [7:0] WDATA_OFS = 8'h08;
	localparam logic [7:0] RDATA_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] CFG_OFS = 8'h14;
	localparam int CFG_PROTECT_BIT = 0;
	localparam logic CFG_PROTECT_RST = 1'b0;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TIMEOUT = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_SUSPENDED = 4;
	localparam int ST_ID_MODE = 5;
	localparam int ST_QUERY_MODE = 6;
	localparam int ST_SECID_MODE = 7;
	localparam int ST_INTERRUPTED = 8;
	localparam int TOGGLE_BIT_A_POS = 6;

	localparam logic [21:0] UNLOCK_ADDR_A = 22'h000555;
	localparam logic [21:0] UNLOCK_ADDR_B = 22'h0002AA;
	localparam logic [21:0] LOCK_ADDR = 22'h000000;
	localparam logic [7:0] UNLOCK_CODE_A = 8'hAA;
	localparam logic [7:0] UNLOCK_CODE_B = 8'h55;
	localparam logic [7:0] UPPER_BYTE = 8'h00;
	localparam logic [15:0] LOCK_DATA = 16'h0000;
	localparam logic [7:0] CMD_PROG = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECT_ERASE = 8'h50;
	localparam logic [7:0] CMD_BLK_ERASE = 8'h30;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
	localparam logic [7:0] CMD_QUERY_ENTRY = 8'h98;
	localparam logic [7:0] CMD_SECID_ENTRY = 8'h88;
	localparam logic [7:0] CMD_SECID_PROG = 8'hA5;
	localparam logic [7:0] CMD_SECID_LOCK = 8'h86;
	localparam logic [7:0] CMD_MODE_EXIT = 8'hF0;

	typedef enum logic [3:0] {
		OP_READ = 4'h0, OP_PROG = 4'h1, OP_SECT_ERASE = 4'h2, OP_BLK_ERASE = 4'h3,
		OP_CHIP_ERASE = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_ID_ENTRY = 4'h7,
		OP_QUERY_ENTRY = 4'h8, OP_SECID_ENTRY = 4'h9, OP_SECID_PROG = 4'hA,
		OP_SECID_LOCK = 4'hB, OP_MODE_EXIT = 4'hC, OP_HW_RESET = 4'hD
	} fcs_op_e;
	localparam logic [3:0] OP_LAST = 4'hD;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b000, SQ_WRITE = 3'b001, SQ_POLL_A = 3'b011, SQ_POLL_B = 3'b010,
		SQ_READ = 3'b110, SQ_WAIT = 3'b111, SQ_RST_LOW = 3'b101, SQ_RST_REC = 3'b100
	} fcs_seq_e;

	typedef enum logic [1:0] {
		CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b11, CY_HOLD = 2'b10
	} fcs_cyc_e;
endpackage

// [src/fcs_cyc_if.sv]
// interface: one flash bus cycle request between sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none
interface fcs_cyc_if;
	logic req;
	logic wr;
	logic abort;
	logic [21:0] addr;
	logic [15:0] wdata;
	logic done;
	logic [15:0] rdata;
	modport seq (output req, output wr, output abort, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input abort, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// [src/fcs_cycle.sv]
// pin engine: one asynchronous flash read or write cycle
`timescale 1ns/1ps
`default_nettype none
module fcs_cycle (
	input wire logic clk_in,
	input wire logic srst_in,
	fcs_cyc_if.eng cyc,
	input wire logic [15:0] fl_dq_in,
	output logic [21:0] fl_addr_out,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe_out,
	output logic fl_ce_n_out,
	output logic fl_oe_n_out,
	output logic fl_we_n_out
);
	fcs_pkg::fcs_cyc_e state_reg;
	logic [2:0] cnt_reg;
	logic wr_reg;
	logic [15:0] rdata_reg;
	wire logic [2:0] strobe_last = wr_reg ? 3'(fcs_pkg::WE_PULSE_CYC - 1) : 3'(fcs_pkg::READ_CYCLE_CYC - 1);

	assign cyc.done = (state_reg == fcs_pkg::CY_HOLD);
	assign cyc.rdata = rdata_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in || cyc.abort) begin
			state_reg <= fcs_pkg::CY_IDLE;
			cnt_reg <= 3'h0;
			wr_reg <= 1'b0;
			fl_ce_n_out <= 1'b1;
			fl_oe_n_out <= 1'b1;
			fl_we_n_out <= 1'b1;
			fl_dq_oe_out <= 1'b0;
		end else begin
			case (state_reg)
				fcs_pkg::CY_IDLE: if (cyc.req) begin
					fl_ce_n_out <= 1'b0;
					fl_dq_oe_out <= cyc.wr;
					wr_reg <= cyc.wr;
					state_reg <= fcs_pkg::CY_SETUP;
				end
				fcs_pkg::CY_SETUP: begin
					// output gate never falls in a write cycle
					fl_we_n_out <= ~wr_reg;
					fl_oe_n_out <= wr_reg;
					cnt_reg <= 3'h0;
					state_reg <= fcs_pkg::CY_STROBE;
				end
				fcs_pkg::CY_STROBE: begin
					cnt_reg <= cnt_reg + 3'h1;
					// strobe width well above the glitch filter
					if (cnt_reg == strobe_last) begin
						fl_we_n_out <= 1'b1;
						fl_oe_n_out <= 1'b1;
						state_reg <= fcs_pkg::CY_HOLD;
					end
				end
				default: begin
					// data still driven here for hold after the write strobe rises
					fl_ce_n_out <= 1'b1;
					fl_dq_oe_out <= 1'b0;
					state_reg <= fcs_pkg::CY_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			fl_addr_out <= 22'h000000;
			fl_dq_out <= 16'h0000;
			rdata_reg <= 16'h0000;
		end else begin
			if (state_reg == fcs_pkg::CY_IDLE && cyc.req && !cyc.abort) begin
				fl_addr_out <= cyc.addr;
				fl_dq_out <= cyc.wdata;
			end
			if (state_reg == fcs_pkg::CY_STROBE && cnt_reg == strobe_last && !wr_reg) begin
				rdata_reg <= fl_dq_in;
			end
		end
	end
endmodule
`default_nettype wire

// [src/fcs_top.sv]
// host controller: apb registers and command sequencer for a x16 nor flash
`timescale 1ns/1ps
`default_nettype none
module fcs_top #(
	parameter int POLL_TIMEOUT_CYC = fcs_pkg::POLL_TIMEOUT_CYC_DEF
) (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic [21:0] FL_ADDR_OUT,
	input wire logic [15:0] FL_DQ_IN,
	output logic [15:0] FL_DQ_OUT,
	output logic FL_DQ_OE_OUT,
	output logic FL_CE_N_OUT,
	output logic FL_OE_N_OUT,
	output logic FL_WE_N_OUT,
	output logic FL_RST_N_OUT,
	output logic FL_WP_N_OUT
);
	fcs_cyc_if cyc();

	fcs_cycle u_cycle (
		.clk_in(CLK_IN),
		.srst_in(SRST_IN),
		.cyc(cyc),
		.fl_dq_in(FL_DQ_IN),
		.fl_addr_out(FL_ADDR_OUT),
		.fl_dq_out(FL_DQ_OUT),
		.fl_dq_oe_out(FL_DQ_OE_OUT),
		.fl_ce_n_out(FL_CE_N_OUT),
		.fl_oe_n_out(FL_OE_N_OUT),
		.fl_we_n_out(FL_WE_N_OUT)
	);

	fcs_pkg::fcs_seq_e state_reg, state_next;
	fcs_pkg::fcs_op_e op_reg, op_next, susp_op_reg, susp_op_next;
	logic [2:0] step_reg, step_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [21:0] addr_reg, op_addr_reg, op_addr_next, saddr_reg, saddr_next;
	logic [15:0] wdata_reg, op_data_reg, op_data_next, rdata_reg, rdata_next;
	logic tog_reg, tog_next, done_reg, done_next, tmo_reg, tmo_next;
	logic ref_reg, ref_next, susp_reg, susp_next, pend_reg, pend_next;
	logic mid_reg, mid_next, mqry_reg, mqry_next, msid_reg, msid_next;
	logic intr_reg, intr_next, retry_reg, retry_next, rst_n_reg, rst_n_next, wp_n_reg;
	logic [31:0] prdata_reg, rd_mux, status_word;
	logic [37:0] step_word_w;

	function automatic logic [2:0] last_step(fcs_pkg::fcs_op_e op);
		case (op)
			fcs_pkg::OP_SECT_ERASE, fcs_pkg::OP_BLK_ERASE, fcs_pkg::OP_CHIP_ERASE: last_step = 3'h5;
			fcs_pkg::OP_PROG, fcs_pkg::OP_SECID_PROG, fcs_pkg::OP_SECID_LOCK: last_step = 3'h3;
			fcs_pkg::OP_SUSPEND, fcs_pkg::OP_RESUME: last_step = 3'h0;
			default: last_step = 3'h2;
		endcase
	endfunction

	function automatic logic is_alter(fcs_pkg::fcs_op_e op);
		is_alter = op inside {fcs_pkg::OP_PROG, fcs_pkg::OP_SECT_ERASE, fcs_pkg::OP_BLK_ERASE,
			fcs_pkg::OP_CHIP_ERASE, fcs_pkg::OP_SECID_PROG, fcs_pkg::OP_SECID_LOCK};
	endfunction

	// address and data of one command cycle; upper byte driven low except in the program data cycle
	function automatic logic [37:0] step_word(fcs_pkg::fcs_op_e op, logic [2:0] step, logic [21:0] a,
			logic [15:0] d);
		logic [7:0] code;
		logic [37:0] w;
		case (op)
			fcs_pkg::OP_PROG: code = fcs_pkg::CMD_PROG;
			fcs_pkg::OP_ID_ENTRY: code = fcs_pkg::CMD_ID_ENTRY;
			fcs_pkg::OP_QUERY_ENTRY: code = fcs_pkg::CMD_QUERY_ENTRY;
			fcs_pkg::OP_SECID_ENTRY: code = fcs_pkg::CMD_SECID_ENTRY;
			fcs_pkg::OP_SECID_PROG: code = fcs_pkg::CMD_SECID_PROG;
			fcs_pkg::OP_SECID_LOCK: code = fcs_pkg::CMD_SECID_LOCK;
			fcs_pkg::OP_MODE_EXIT: code = fcs_pkg::CMD_MODE_EXIT;
			default: code = fcs_pkg::CMD_ERASE_SETUP;
		endcase
		w = {fcs_pkg::UNLOCK_ADDR_A, fcs_pkg::UPPER_BYTE, fcs_pkg::UNLOCK_CODE_A};
		case (step)
			3'h1, 3'h4: w = {fcs_pkg::UNLOCK_ADDR_B, fcs_pkg::UPPER_BYTE, fcs_pkg::UNLOCK_CODE_B};
			3'h2: w = {fcs_pkg::UNLOCK_ADDR_A, fcs_pkg::UPPER_BYTE, code};
			3'h3: begin
				if (op == fcs_pkg::OP_SECID_LOCK) begin
					w = {fcs_pkg::LOCK_ADDR, fcs_pkg::LOCK_DATA};
				end else if (last_step(op) == 3'h3) begin
					w = {a, d};
				end
			end
			3'h5: begin
				if (op == fcs_pkg::OP_CHIP_ERASE) begin
					w = {fcs_pkg::UNLOCK_ADDR_A, fcs_pkg::UPPER_BYTE, fcs_pkg::CMD_CHIP_ERASE};
				end else if (op == fcs_pkg::OP_SECT_ERASE) begin
					w = {a, fcs_pkg::UPPER_BYTE, fcs_pkg::CMD_SECT_ERASE};
				end else begin
					w = {a, fcs_pkg::UPPER_BYTE, fcs_pkg::CMD_BLK_ERASE};
				end
			end
			default: begin
				// suspend and resume are a single cycle at any address
				if (op == fcs_pkg::OP_SUSPEND) begin
					w = {a, fcs_pkg::UPPER_BYTE, fcs_pkg::CMD_SUSPEND};
				end else if (op == fcs_pkg::OP_RESUME) begin
					w = {a, fcs_pkg::UPPER_BYTE, fcs_pkg::CMD_RESUME};
				end
			end
		endcase
		step_word = w;
	endfunction

	// apb slave, zero wait states
	wire logic apb_acc = PSEL_IN & PENABLE_IN;
	wire logic apb_wr = apb_acc & PWRITE_IN;
	wire logic hit_ctrl = (PADDR_IN == fcs_pkg::CTRL_OFS);
	wire logic hit_addr = (PADDR_IN == fcs_pkg::ADDR_OFS);
	wire logic hit_wdata = (PADDR_IN == fcs_pkg::WDATA_OFS);
	wire logic hit_rdata = (PADDR_IN == fcs_pkg::RDATA_OFS);
	wire logic hit_status = (PADDR_IN == fcs_pkg::STATUS_OFS);
	wire logic hit_cfg = (PADDR_IN == fcs_pkg::CFG_OFS);
	wire logic hit_any = hit_ctrl | hit_addr | hit_wdata | hit_rdata | hit_status | hit_cfg;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = apb_acc & ~hit_any;
	assign PRDATA_OUT = prdata_reg;
	assign FL_RST_N_OUT = rst_n_reg;
	assign FL_WP_N_OUT = wp_n_reg;

	// command decode; only reset, or suspend of a polled sector or block erase, may cut in while busy
	wire logic start_wr = apb_wr & hit_ctrl;
	wire logic op_valid = (PWDATA_IN[3:0] <= fcs_pkg::OP_LAST);
	wire fcs_pkg::fcs_op_e new_op = fcs_pkg::fcs_op_e'(PWDATA_IN[3:0]);
	wire logic polling = (state_reg == fcs_pkg::SQ_POLL_A) | (state_reg == fcs_pkg::SQ_POLL_B);
	wire logic erase_polled = polling & (op_reg inside {fcs_pkg::OP_SECT_ERASE, fcs_pkg::OP_BLK_ERASE});
	wire logic accept_rst = start_wr & op_valid & (new_op == fcs_pkg::OP_HW_RESET);
	wire logic accept_susp = start_wr & op_valid & (new_op == fcs_pkg::OP_SUSPEND) & erase_polled & ~pend_reg;
	wire logic accept_new = start_wr & op_valid & ~accept_rst & (state_reg == fcs_pkg::SQ_IDLE);
	wire logic refuse = start_wr & ~accept_rst & ~accept_susp & ~accept_new;
	wire logic alter_busy = is_alter(op_reg) & (state_reg inside {fcs_pkg::SQ_WRITE, fcs_pkg::SQ_POLL_A,
		fcs_pkg::SQ_POLL_B});
	wire logic tog_now = cyc.rdata[fcs_pkg::TOGGLE_BIT_A_POS];

	assign step_word_w = step_word(op_reg, step_reg, op_addr_reg, op_data_reg);
	assign cyc.req = state_reg inside {fcs_pkg::SQ_WRITE, fcs_pkg::SQ_POLL_A, fcs_pkg::SQ_POLL_B,
		fcs_pkg::SQ_READ};
	assign cyc.wr = (state_reg == fcs_pkg::SQ_WRITE);
	assign cyc.abort = (state_reg == fcs_pkg::SQ_RST_LOW);
	assign cyc.addr = cyc.wr ? step_word_w[37:16] : op_addr_reg;
	assign cyc.wdata = step_word_w[15:0];

	always_comb begin
		status_word = 32'h00000000;
		status_word[fcs_pkg::ST_BUSY] = (state_reg != fcs_pkg::SQ_IDLE);
		status_word[fcs_pkg::ST_DONE] = done_reg;
		status_word[fcs_pkg::ST_TIMEOUT] = tmo_reg;
		status_word[fcs_pkg::ST_REFUSED] = ref_reg;
		status_word[fcs_pkg::ST_SUSPENDED] = susp_reg;
		status_word[fcs_pkg::ST_ID_MODE] = mid_reg;
		status_word[fcs_pkg::ST_QUERY_MODE] = mqry_reg;
		status_word[fcs_pkg::ST_SECID_MODE] = msid_reg;
		status_word[fcs_pkg::ST_INTERRUPTED] = intr_reg;
	end

	always_comb begin
		if (hit_ctrl) begin
			rd_mux = {28'h0000000, op_reg};
		end else if (hit_addr) begin
			rd_mux = {10'h000, addr_reg};
		end else if (hit_wdata) begin
			rd_mux = {16'h0000, wdata_reg};
		end else if (hit_rdata) begin
			rd_mux = {16'h0000, rdata_reg};
		end else if (hit_status) begin
			rd_mux = status_word;
		end else if (hit_cfg) begin
			rd_mux = {31'h00000000, ~wp_n_reg};
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		susp_op_next = susp_op_reg;
		step_next = step_reg;
		cnt_next = cnt_reg;
		op_addr_next = op_addr_reg;
		op_data_next = op_data_reg;
		saddr_next = saddr_reg;
		rdata_next = rdata_reg;
		tog_next = tog_reg;
		done_next = done_reg;
		tmo_next = tmo_reg;
		ref_next = ref_reg | refuse;
		susp_next = susp_reg;
		pend_next = pend_reg | accept_susp;
		mid_next = mid_reg;
		mqry_next = mqry_reg;
		msid_next = msid_reg;
		intr_next = intr_reg;
		retry_next = retry_reg;
		rst_n_next = rst_n_reg;
		if (accept_new) begin
			op_next = new_op;
			op_addr_next = addr_reg;
			op_data_next = wdata_reg;
			step_next = 3'h0;
			cnt_next = 32'h00000000;
			done_next = 1'b0;
			tmo_next = 1'b0;
			ref_next = refuse;
			state_next = (new_op == fcs_pkg::OP_READ) ? fcs_pkg::SQ_READ : fcs_pkg::SQ_WRITE;
		end
		case (state_reg)
			fcs_pkg::SQ_WRITE: if (cyc.done) begin
				step_next = step_reg + 3'h1;
				if (step_reg == last_step(op_reg)) begin
					step_next = 3'h0;
					cnt_next = 32'h00000000;
					state_next = fcs_pkg::SQ_IDLE;
					done_next = 1'b1;
					case (op_reg)
						fcs_pkg::OP_SUSPEND: begin
							done_next = 1'b0;
							state_next = fcs_pkg::SQ_WAIT;
						end
						fcs_pkg::OP_RESUME: if (susp_reg) begin
							// go back to watching the resumed erase
							susp_next = 1'b0;
							op_next = susp_op_reg;
							op_addr_next = saddr_reg;
							done_next = 1'b0;
							state_next = fcs_pkg::SQ_POLL_A;
						end
						fcs_pkg::OP_ID_ENTRY: mid_next = 1'b1;
						fcs_pkg::OP_QUERY_ENTRY: mqry_next = 1'b1;
						fcs_pkg::OP_SECID_ENTRY: msid_next = 1'b1;
						fcs_pkg::OP_MODE_EXIT: begin
							// exit only issued from idle, never under a running program
							mid_next = 1'b0;
							mqry_next = 1'b0;
							msid_next = 1'b0;
						end
						fcs_pkg::OP_READ, fcs_pkg::OP_HW_RESET: state_next = fcs_pkg::SQ_IDLE;
						default: begin
							// completion watched on toggle_bit_a only, never poll_bit
							done_next = 1'b0;
							state_next = fcs_pkg::SQ_POLL_A;
						end
					endcase
				end
			end
			fcs_pkg::SQ_POLL_A, fcs_pkg::SQ_POLL_B: begin
				cnt_next = cnt_reg + 32'h00000001;
				if (cyc.done) begin
					tog_next = tog_now;
					state_next = fcs_pkg::SQ_POLL_B;
					if (pend_reg) begin
						// no new command until the suspend write is out
						pend_next = 1'b0;
						susp_next = 1'b1;
						susp_op_next = op_reg;
						saddr_next = op_addr_reg;
						op_next = fcs_pkg::OP_SUSPEND;
						step_next = 3'h0;
						state_next = fcs_pkg::SQ_WRITE;
					end else if (state_reg == fcs_pkg::SQ_POLL_B && tog_now == tog_reg) begin
						// toggling stopped: the word read is true data
						rdata_next = cyc.rdata;
						done_next = 1'b1;
						state_next = fcs_pkg::SQ_IDLE;
					end else if (cnt_reg >= 32'(POLL_TIMEOUT_CYC)) begin
						tmo_next = 1'b1;
						done_next = 1'b1;
						state_next = fcs_pkg::SQ_IDLE;
					end
				end
			end
			fcs_pkg::SQ_READ: if (cyc.done) begin
				rdata_next = cyc.rdata;
				done_next = 1'b1;
				state_next = fcs_pkg::SQ_IDLE;
			end
			fcs_pkg::SQ_WAIT: begin
				cnt_next = cnt_reg + 32'h00000001;
				// device needs time to settle into read after a suspend
				if (cnt_reg == 32'(fcs_pkg::SUSPEND_WAIT_CYC - 1)) begin
					done_next = 1'b1;
					state_next = fcs_pkg::SQ_IDLE;
				end
			end
			fcs_pkg::SQ_RST_LOW: begin
				cnt_next = cnt_reg + 32'h00000001;
				if (cnt_reg == 32'(fcs_pkg::RESET_PULSE_CYC - 1)) begin
					rst_n_next = 1'b1;
					cnt_next = 32'h00000000;
					state_next = fcs_pkg::SQ_RST_REC;
				end
			end
			fcs_pkg::SQ_RST_REC: begin
				cnt_next = cnt_reg + 32'h00000001;
				if (cnt_reg == 32'(fcs_pkg::RESET_RECOVERY_CYC - 1)) begin
					retry_next = 1'b0;
					step_next = 3'h0;
					cnt_next = 32'h00000000;
					// cut program or erase goes out again from its first cycle
					state_next = retry_reg ? fcs_pkg::SQ_WRITE : fcs_pkg::SQ_IDLE;
					done_next = ~retry_reg;
				end
			end
			default: state_next = state_next;
		endcase
		if (accept_rst) begin
			// pin reset aborts the engine and clears modes and partial sequences
			state_next = fcs_pkg::SQ_RST_LOW;
			cnt_next = 32'h00000000;
			rst_n_next = 1'b0;
			done_next = 1'b0;
			pend_next = 1'b0;
			susp_next = 1'b0;
			mid_next = 1'b0;
			mqry_next = 1'b0;
			msid_next = 1'b0;
			intr_next = intr_reg | alter_busy | susp_reg;
			retry_next = alter_busy | susp_reg;
			if (susp_reg && !alter_busy) begin
				op_next = susp_op_reg;
				op_addr_next = saddr_reg;
			end
		end else if (accept_new) begin
			intr_next = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			state_reg <= fcs_pkg::SQ_IDLE;
			op_reg <= fcs_pkg::OP_READ;
			susp_op_reg <= fcs_pkg::OP_READ;
			{step_reg, cnt_reg, op_addr_reg, op_data_reg, saddr_reg, rdata_reg} <= '0;
			{tog_reg, done_reg, tmo_reg, ref_reg, susp_reg, pend_reg} <= '0;
			{mid_reg, mqry_reg, msid_reg, intr_reg, retry_reg} <= '0;
			rst_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			susp_op_reg <= susp_op_next;
			{step_reg, cnt_reg, op_addr_reg, op_data_reg, saddr_reg, rdata_reg} <=
				{step_next, cnt_next, op_addr_next, op_data_next, saddr_next, rdata_next};
			{tog_reg, done_reg, tmo_reg, ref_reg, susp_reg, pend_reg} <=
				{tog_next, done_next, tmo_next, ref_next, susp_next, pend_next};
			{mid_reg, mqry_reg, msid_reg, intr_reg, retry_reg} <=
				{mid_next, mqry_next, msid_next, intr_next, retry_next};
			rst_n_reg <= rst_n_next;
		end
	end

	// boot protect pin is a plain software level
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			addr_reg <= 22'h000000;
			wdata_reg <= 16'h0000;
			wp_n_reg <= ~fcs_pkg::CFG_PROTECT_RST;
			prdata_reg <= 32'h00000000;
		end else begin
			if (apb_wr && hit_addr) addr_reg <= PWDATA_IN[21:0];
			if (apb_wr && hit_wdata) wdata_reg <= PWDATA_IN[15:0];
			if (apb_wr && hit_cfg) wp_n_reg <= ~PWDATA_IN[fcs_pkg::CFG_PROTECT_BIT];
			if (PSEL_IN && !PENABLE_IN) prdata_reg <= rd_mux;
		end
	end
endmodule
`default_nettype wire

// [bench/fcs_monitor.sv]
// checker on the flash pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module fcs_monitor (input wire logic CLK_IN, SRST_IN, FL_CE_N_OUT, FL_OE_N_OUT, FL_WE_N_OUT, FL_DQ_OE_OUT,
	input wire logic FL_RST_N_OUT, input wire logic [21:0] FL_ADDR_OUT, input wire logic [15:0] FL_DQ_OUT);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	property p_inh; !FL_WE_N_OUT |-> !FL_CE_N_OUT && FL_OE_N_OUT && FL_DQ_OE_OUT; endproperty
	a_inh: assert property (p_inh) else $error("strobe outside write cycle");
	property p_up; !FL_WE_N_OUT && (FL_ADDR_OUT == 22'h000555 || FL_ADDR_OUT == 22'h0002AA) |-> FL_DQ_OUT[15:8] == 8'h00;
	endproperty
	a_up: assert property (p_up) else $error("upper byte not zero");
	property p_oe; !FL_OE_N_OUT |-> !FL_DQ_OE_OUT && FL_WE_N_OUT; endproperty
	a_oe: assert property (p_oe) else $error("host drives during read");
	// a pin reset may cut a cycle short: the engine aborts one clock after the reset pin falls
	property p_wl; $fell(FL_WE_N_OUT) |-> !FL_CE_N_OUT ##1 (!FL_WE_N_OUT || !FL_RST_N_OUT) ##1
		(FL_WE_N_OUT && (!FL_CE_N_OUT || !FL_RST_N_OUT)); endproperty
	a_wl: assert property (p_wl) else $error("write pulse shape");
	property p_rd; $fell(FL_OE_N_OUT) |-> (!FL_OE_N_OUT || !FL_RST_N_OUT) [*3] ##1 FL_OE_N_OUT; endproperty
	a_rd: assert property (p_rd) else $error("read pulse shape");
	property p_u1; $fell(FL_WE_N_OUT) && FL_ADDR_OUT == 22'h000555 && FL_DQ_OUT[7:0] == 8'hAA |->
		##[3:12] ($fell(FL_WE_N_OUT) && FL_ADDR_OUT == 22'h0002AA && FL_DQ_OUT[7:0] == 8'h55); endproperty
	a_u1: assert property (p_u1) else $error("second unlock cycle missing");
	property p_rp; $fell(FL_RST_N_OUT) |-> ##19 !FL_RST_N_OUT; endproperty
	a_rp: assert property (p_rp) else $error("reset pulse short");
	property p_rhr; $rose(FL_RST_N_OUT) |-> FL_OE_N_OUT throughout (##39 1'b1); endproperty
	a_rhr: assert property (p_rhr) else $error("read inside reset recovery");
	cover property ($fell(FL_RST_N_OUT));
	cover property ($fell(FL_WE_N_OUT) && FL_DQ_OUT[7:0] == 8'h80);
	cover property ($fell(FL_OE_N_OUT));
endmodule
bind fcs_top fcs_monitor mon_u (.*);
`default_nettype wire

// [bench/fcs_flash_model.sv]
// behavioural nor flash answering the host pins
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(parameter logic [15:0] MAKER = 16'h00A1, DEVICE = 16'h0B2C) ( // codes arbitrary
	input wire logic clk_in, ce_n_in, oe_n_in, we_n_in, rst_n_in, wp_n_in,
	input wire logic [21:0] a_in, input wire logic [15:0] d_in, output logic [15:0] q_out);
	logic [15:0] mem [16] = '{default: 16'hFFFF};
	logic [15:0] rd, last_q = 16'h0000;
	logic [7:0] busy = 8'h00;
	logic [2:0] st = 3'd0;
	logic we_q = 1'b1, oe_q = 1'b1, tgl = 1'b0, ers = 1'b0, id = 1'b0;
	wire [3:0] w = a_in[3:0];
	wire [7:0] c = d_in[7:0]; // upper byte ignored
	wire wr = we_n_in && !we_q && !ce_n_in && oe_n_in; // sampled strobe, inhibit
	wire u1 = a_in == 22'h000555 && c == 8'hAA;
	wire u2 = a_in == 22'h0002AA && c == 8'h55;
	wire prot = !wp_n_in && a_in < 22'h008000; // bottom variant, chip erase at 555 too
	assign rd = busy != 8'h00 ? {8'h00, !ers && !mem[w][7], tgl, 3'b000, ers && tgl, 2'b00} :
		id ? (a_in[0] ? DEVICE : MAKER) : mem[w];
	assign q_out = !ce_n_in && !oe_n_in ? rd : ~last_q; // released bus never holds
	always @(posedge clk_in) begin
		we_q <= we_n_in; oe_q <= oe_n_in; last_q <= q_out;
		if (busy != 8'h00) busy <= busy - 8'h01;
		if (busy != 8'h00 && oe_n_in && !oe_q) tgl <= !tgl;
		if (!rst_n_in) begin st <= 3'd0; busy <= 8'h00; id <= 1'b0; end
		else if (wr && busy == 8'h00) case (st) // writes while busy dropped, exit too
			3'd0, 3'd4: st <= u1 ? st + 3'd1 : 3'd0;
			3'd1, 3'd5: st <= u2 ? st + 3'd1 : 3'd0;
			3'd2: begin st <= c == 8'hA0 ? 3'd3 : c == 8'h80 ? 3'd4 : 3'd0; id <= c == 8'h90 || (id && c != 8'hF0); end
			3'd3: begin st <= 3'd0; ers <= 1'b0; if (!prot) begin mem[w] <= mem[w] & d_in; busy <= 8'd30; end end
			default: begin st <= 3'd0; ers <= 1'b1; if (!prot) begin mem <= '{default: 16'hFFFF}; busy <= 8'd60; end end
		endcase
	end
endmodule
`default_nettype wire

// [bench/fcs_top_tb.sv]
// self-checking bench: apb stimulus of the host against a flash model
`timescale 1ns/1ps
`default_nettype none
module fcs_top_tb;
	logic CLK_IN = 0, SRST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, PREADY_OUT, PSLVERR_OUT, err;
	logic FL_DQ_OE_OUT, FL_CE_N_OUT, FL_OE_N_OUT, FL_WE_N_OUT, FL_RST_N_OUT, FL_WP_N_OUT;
	logic [7:0] PADDR_IN = 8'h00;
	logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, rd;
	logic [21:0] FL_ADDR_OUT;
	logic [15:0] FL_DQ_IN, FL_DQ_OUT, fq;
	int fail_count = 0, samples_checked = 0, cyc = 0;
	assign FL_DQ_IN = FL_DQ_OE_OUT ? FL_DQ_OUT : fq;
	fcs_top #(.POLL_TIMEOUT_CYC(200)) dut_u (.*);
	fcs_flash_model fl_u (.clk_in(CLK_IN), .ce_n_in(FL_CE_N_OUT), .oe_n_in(FL_OE_N_OUT), .we_n_in(FL_WE_N_OUT),
		.rst_n_in(FL_RST_N_OUT), .wp_n_in(FL_WP_N_OUT), .a_in(FL_ADDR_OUT), .d_in(FL_DQ_OUT), .q_out(fq));
	initial forever #12.5 CLK_IN = !CLK_IN;
	always @(posedge CLK_IN) if (++cyc == 30000) begin fail_count++; summarize(); end
	task automatic summarize();
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin fail_count++; $display("CHECK FAILED %0t seen %h expected %h", $time, s, e); end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_IN) begin PSEL_IN <= 1; PWRITE_IN <= w; PADDR_IN <= a; PWDATA_IN <= d; end
		@(posedge CLK_IN) PENABLE_IN <= 1;
		do @(posedge CLK_IN); while (PREADY_OUT !== 1'b1);
		rd = PRDATA_OUT; err = PSLVERR_OUT; PSEL_IN <= 0; PENABLE_IN <= 0;
	endtask
	// polling is bounded so a stuck busy flag ends in a mismatch, not a hang
	task automatic op(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d, input logic wt);
		apb(1, fcs_pkg::ADDR_OFS, {10'h000, a});
		apb(1, fcs_pkg::WDATA_OFS, {16'h0000, d});
		apb(1, fcs_pkg::CTRL_OFS, {28'h0000000, o});
		rd = 32'h1;
		for (int i = 0; i < 500 && wt && rd[fcs_pkg::ST_BUSY] !== 1'b0; i++) apb(0, fcs_pkg::STATUS_OFS, 32'h0);
	endtask
	task automatic peek(input logic [21:0] a, input logic [31:0] e);
		op(4'h0, a, 16'h0000, 1);
		apb(0, fcs_pkg::RDATA_OFS, 32'h0);
		chk(rd, e);
	endtask
	initial begin
		repeat (10) @(posedge CLK_IN);
		SRST_IN <= 0;
		apb(0, fcs_pkg::CFG_OFS, 32'h0);
		chk(rd, 32'(fcs_pkg::CFG_PROTECT_RST));
		apb(0, 8'h18, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		op(4'h1, 22'h000009, 16'h1234, 1);
		chk(32'(rd[fcs_pkg::ST_DONE]), 32'h1);
		peek(22'h000009, 32'h00001234);
		op(4'h7, 22'h000000, 16'h0000, 1);
		peek(22'h000000, 32'h000000A1);
		peek(22'h000001, 32'h00000B2C);
		op(4'hC, 22'h000000, 16'h0000, 1);
		peek(22'h000009, 32'h00001234);
		apb(1, fcs_pkg::CFG_OFS, 32'h1);
		op(4'h2, 22'h000008, 16'h0000, 1);
		peek(22'h000009, 32'h00001234);
		apb(1, fcs_pkg::CFG_OFS, 32'h0);
		op(4'h2, 22'h000008, 16'h0000, 1);
		peek(22'h000009, 32'h0000FFFF);
		op(4'h1, 22'h000009, 16'h0055, 0);
		repeat (26) @(posedge CLK_IN);
		op(4'hD, 22'h000009, 16'h0055, 1);
		chk(32'(rd[fcs_pkg::ST_INTERRUPTED]), 32'h1);
		peek(22'h000009, 32'h00000055);
		op(4'h8, 22'h000000, 16'h0000, 1);
		chk(32'(rd[fcs_pkg::ST_QUERY_MODE]), 32'h1);
		op(4'h9, 22'h000000, 16'h0000, 1);
		chk(32'(rd[fcs_pkg::ST_SECID_MODE]), 32'h1);
		op(4'hC, 22'h000000, 16'h0000, 1);
		chk(32'(rd[7:5]), 32'h0);
		op(4'h3, 22'h000008, 16'h0000, 0);
		repeat (30) @(posedge CLK_IN);
		op(4'h5, 22'h000008, 16'h0000, 1);
		chk(32'(rd[fcs_pkg::ST_SUSPENDED]), 32'h1);
		op(4'h6, 22'h000008, 16'h0000, 1);
		chk(32'(rd[fcs_pkg::ST_SUSPENDED]), 32'h0);
		apb(1, fcs_pkg::CTRL_OFS, 32'hE);
		apb(0, fcs_pkg::STATUS_OFS, 32'h0);
		chk(32'(rd[fcs_pkg::ST_REFUSED]), 32'h1);
		summarize();
	end
endmodule
`default_nettype wire
